// File: dim_pkg.sv
// Constants shared by the LED dimming duty control
`default_nettype none
package dim_pkg;
   // ****************************************
   // Strap decoding
   // ****************************************
   typedef enum logic [1:0] {mode_direct, mode_mixed, mode_dc, mode_off} dim_mode_t;

   // ****************************************
   // Amplitude code and thresholds
   // ****************************************
   localparam int AMP_W = 9;
   localparam logic [AMP_W-1:0] AMP_FULL = 9'h1ff;
   localparam logic [AMP_W-1:0] AMP_QUARTER = 9'h080;
   localparam int QUARTER_SHIFT = 2;
   localparam int DUTY_MULT_SHIFT = 2;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int MIN_FREQ_HZ = 100;
   localparam int MAX_FREQ_HZ = 20000;
   localparam int MAX_PERIOD_CYC = CLK_MHZ * 1000000 / MIN_FREQ_HZ;
   localparam int MIN_PERIOD_CYC = CLK_MHZ * 1000000 / MAX_FREQ_HZ;
   localparam int SOFT_DIRECT_MS = 20;
   localparam int SOFT_MIXED_MS = 40;
   localparam int SOFT_DIRECT_CYC = SOFT_DIRECT_MS * CLK_MHZ * 1000;
   localparam int SOFT_MIXED_CYC = SOFT_MIXED_MS * CLK_MHZ * 1000;
endpackage
`default_nettype wire

// File: dim_sva.sv
// Port checker for the LED dimming duty control
`default_nettype none
module dim_sva
   import dim_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic strap_at_rail,
   input wire logic strap_at_ground,
   input wire logic supply_ok,
   input wire logic enable_in,
   input wire logic pwm_in,
   input wire logic [5:0] sink_on,
   input wire logic [AMP_W-1:0] current_set_reference,
   input wire logic started
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire dir = strap_at_rail & ~strap_at_ground;
   wire mix = ~strap_at_rail & ~strap_at_ground;
   wire dcm = strap_at_ground & ~strap_at_rail;
   // Input rises seen since start, counted on the same edges as the design
   logic pwm_prev_q;
   logic [1:0] rises_d, rises_q;
   always_comb begin
      rises_d = rises_q;
      if (!started) rises_d = 2'h0;
      else if (pwm_in && !pwm_prev_q && rises_q != 2'h2) rises_d = rises_q + 2'h1;
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pwm_prev_q <= 1'b0;
         rises_q <= 2'h0;
      end else begin
         pwm_prev_q <= pwm_in;
         rises_q <= rises_d;
      end
   end
   sinks_same_a:
      assert property (sink_on == 6'h00 || sink_on == 6'h3f) else $error("sinks differ");
   start_gate_a:
      assert property ($rose(started) |-> $past(supply_ok && enable_in)) else $error("early start");
   drop_clear_a:
      assert property (!(supply_ok && enable_in) |=> !started) else $error("start kept");
   start_hold_a:
      assert property (started && supply_ok && enable_in |=> started) else $error("start lost");
   direct_follow_a:
      assert property (dir && started && $past(dir && started) |-> sink_on == {6{$past(pwm_in)}})
      else $error("sinks not in step with pwm");
   dc_steady_a:
      assert property (dcm && started && $past(dcm && started && sink_on[0]) |-> sink_on[0])
      else $error("dc mode pulsed");
   low_amp_a:
      assert property (mix && started && $fell(sink_on[0]) |-> current_set_reference <= AMP_QUARTER)
      else $error("pulsing above quarter amplitude");
   mix_lag_a:
      assert property ($rose(started) && mix |-> !sink_on[0] [*8]) else $error("no lag");
   idle_dark_a:
      assert property (!started && !$past(started) |-> sink_on == 6'h00) else $error("lit idle");
   mix_wait_a:
      assert property (mix && rises_q != 2'h2 |-> sink_on == 6'h00) else $error("mixed lit early");
   dc_wait_a:
      assert property (dcm && rises_q != 2'h2 |-> sink_on == 6'h00) else $error("dc lit early");
   ramp_up_a:
      assert property (dir && $past(dir) && started && $past(started)
         |-> current_set_reference >= $past(current_set_reference)) else $error("ramp fell");
endmodule
bind led_dimming_duty_control dim_sva i_dim_sva (.mclk(mclk), .sys_rst(sys_rst),
   .strap_at_rail(strap_at_rail), .strap_at_ground(strap_at_ground), .supply_ok(supply_ok),
   .enable_in(enable_in), .pwm_in(pwm_in), .sink_on(sink_on),
   .current_set_reference(current_set_reference), .started(started));
`default_nettype wire

// File: led_dimming_duty_control.sv
// LED dimming duty control: strap decode, duty measurement, sink drive
// Functional notes
// - Direct mode: sinks follow PWM input
// - Direct mode only with strap at rail
// - Floating strap selects mixed dimming mode
// - Mixed output lags input by two periods
// - Duty 25-100 percent gives scaled DC
// - Below 25 percent: quarter amplitude, 4x duty
// - Strap at ground: pure DC, same lag
// - Amplitude code is nine bits, 512 steps
// - Start only with supply, PWM, enable valid
// - Soft-start ramp, length depends on mode
// - Accept input from 100 Hz to 20 kHz
// - One reference drives all six sinks
`default_nettype none
module led_dimming_duty_control
   import dim_pkg::*;
#(
   parameter int CNT_W = 24,
   parameter int SOFT_DIRECT = SOFT_DIRECT_CYC,
   parameter int SOFT_MIXED = SOFT_MIXED_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic strap_at_rail,
   input wire logic strap_at_ground,
   input wire logic supply_ok,
   input wire logic enable_in,
   input wire logic pwm_in,
   output logic [5:0] sink_on,
   output logic [AMP_W-1:0] current_set_reference,
   output logic started
);
   // ****************************************
   // Parameter checks
   // ****************************************
   if (CNT_W < 24 || (1 << CNT_W) <= MAX_PERIOD_CYC) begin : g_cnt_chk
      $error("CNT_W too narrow for slowest input period");
   end
   if (SOFT_DIRECT < 1 || SOFT_MIXED < 1 || SOFT_DIRECT >= (1 << CNT_W)) begin : g_soft_chk
      $error("Soft-start counts out of range");
   end
   if (SOFT_MIXED >= (1 << CNT_W)) begin : g_mixed_chk
      $error("Soft-start counts out of range");
   end

   // ****************************************
   // Strap decode and input edges
   // ****************************************
   dim_mode_t mode;
   always_comb begin
      if (strap_at_rail && !strap_at_ground) mode = mode_direct;
      else if (strap_at_ground && !strap_at_rail) mode = mode_dc;
      else if (!strap_at_ground && !strap_at_rail) mode = mode_mixed;
      else mode = mode_off;
   end

   logic pwm_q, pwm_d;
   logic rise;
   assign pwm_d = pwm_in;
   assign rise = pwm_in && !pwm_q;

   // ****************************************
   // Start-up and soft-start
   // ****************************************
   logic started_d, started_q;
   logic [CNT_W-1:0] ss_cnt_d, ss_cnt_q;
   logic [AMP_W-1:0] ramp_d, ramp_q;
   logic seen_pwm_d, seen_pwm_q;
   logic [CNT_W-1:0] ss_len;
   always_comb begin
      ss_len = (mode == mode_direct) ? CNT_W'(SOFT_DIRECT) : CNT_W'(SOFT_MIXED);
      started_d = started_q;
      ss_cnt_d = ss_cnt_q;
      ramp_d = ramp_q;
      seen_pwm_d = seen_pwm_q || pwm_in;
      if (!supply_ok || !enable_in) begin
         started_d = 1'b0;
         ss_cnt_d = '0;
         ramp_d = '0;
         seen_pwm_d = 1'b0;
      end else if (!started_q) begin
         if (seen_pwm_q && mode != mode_off) started_d = 1'b1;
      end else if (ramp_q != AMP_FULL) begin
         if (ss_cnt_q >= (ss_len >> AMP_W)) begin
            ss_cnt_d = '0;
            ramp_d = ramp_q + 9'h001;
         end else begin
            ss_cnt_d = ss_cnt_q + 1'b1;
         end
      end
   end

   // ****************************************
   // Duty measurement
   // ****************************************
   logic [CNT_W-1:0] per_cnt_d, per_cnt_q, hi_cnt_d, hi_cnt_q;
   logic [CNT_W-1:0] per_d, per_q, hi_d, hi_q;
   logic meas_ok_d, meas_ok_q, calc_d, calc_q;
   logic duty_ok_d, duty_ok_q;
   logic [AMP_W-1:0] duty_d, duty_q;
   logic [CNT_W+AMP_W-1:0] prod;
   always_comb begin
      per_cnt_d = per_cnt_q;
      hi_cnt_d = hi_cnt_q;
      per_d = per_q;
      hi_d = hi_q;
      meas_ok_d = meas_ok_q;
      calc_d = 1'b0;
      duty_d = duty_q;
      duty_ok_d = duty_ok_q;
      prod = (CNT_W+AMP_W)'(hi_q) * (CNT_W+AMP_W)'(AMP_FULL);
      if (rise) begin
         per_d = per_cnt_q + 1'b1;
         hi_d = hi_cnt_q;
         per_cnt_d = '0;
         // Rise cycle is already high time
         hi_cnt_d = CNT_W'(1'b1);
         calc_d = meas_ok_q;
         meas_ok_d = 1'b1;
      end else begin
         if (per_cnt_q != '1) per_cnt_d = per_cnt_q + 1'b1;
         if (pwm_in && hi_cnt_q != '1) hi_cnt_d = hi_cnt_q + 1'b1;
      end
      if (calc_q && per_q != '0) begin
         duty_d = AMP_W'(prod / (CNT_W+AMP_W)'(per_q));
         duty_ok_d = 1'b1;
      end
      // Stale duty from an earlier run must not light the sinks
      if (!started_q) begin
         meas_ok_d = 1'b0;
         duty_ok_d = 1'b0;
      end
   end

   // ****************************************
   // Amplitude and sink drive
   // ****************************************
   logic [5:0] sink_d;
   logic [AMP_W-1:0] amp_d, scaled;
   logic [CNT_W+1:0] burst_len;
   logic burst;
   always_comb begin
      burst_len = (CNT_W+2)'(hi_q) << DUTY_MULT_SHIFT;
      burst = (CNT_W+2)'(per_cnt_q) < burst_len;
      scaled = duty_q;
      amp_d = '0;
      sink_d = '0;
      if (started_q) begin
         unique case (mode)
            mode_direct: begin
               amp_d = AMP_FULL;
               sink_d = {6{pwm_in}};
            end
            mode_mixed: begin
               if (duty_q >= (AMP_FULL >> QUARTER_SHIFT) + 9'h001) begin
                  amp_d = scaled;
                  sink_d = {6{duty_ok_q}};
               end else begin
                  amp_d = AMP_QUARTER;
                  sink_d = {6{duty_ok_q && burst}};
               end
            end
            mode_dc: begin
               amp_d = scaled;
               sink_d = {6{duty_ok_q}};
            end
            mode_off: begin
               amp_d = '0;
               sink_d = '0;
            end
         endcase
         if (amp_d > ramp_q) amp_d = ramp_q;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pwm_q <= 1'b0;
         started_q <= 1'b0;
         ss_cnt_q <= '0;
         ramp_q <= '0;
         seen_pwm_q <= 1'b0;
         per_cnt_q <= '0;
         hi_cnt_q <= '0;
         per_q <= '0;
         hi_q <= '0;
         meas_ok_q <= 1'b0;
         calc_q <= 1'b0;
         duty_ok_q <= 1'b0;
         duty_q <= '0;
         sink_on <= '0;
         current_set_reference <= '0;
         started <= 1'b0;
      end else begin
         pwm_q <= pwm_d;
         started_q <= started_d;
         ss_cnt_q <= ss_cnt_d;
         ramp_q <= ramp_d;
         seen_pwm_q <= seen_pwm_d;
         per_cnt_q <= per_cnt_d;
         hi_cnt_q <= hi_cnt_d;
         per_q <= per_d;
         hi_q <= hi_d;
         meas_ok_q <= meas_ok_d;
         calc_q <= calc_d;
         duty_ok_q <= duty_ok_d;
         duty_q <= duty_d;
         sink_on <= sink_d;
         current_set_reference <= amp_d;
         started <= started_d;
      end
   end
endmodule
`default_nettype wire

// File: pwm_host.sv
// Host model: brightness PWM source with set period and high time
`default_nettype none
module pwm_host (
   input wire logic mclk,
   input wire logic run,
   input wire logic [23:0] period,
   input wire logic [23:0] high_time,
   output logic pwm_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] cnt_q;
   always @(posedge mclk) begin
      if (!run) begin
         cnt_q <= 24'h000000;
         pwm_out <= 1'b0;
      end else begin
         cnt_q <= (cnt_q + 24'h000001 >= period) ? 24'h000000 : cnt_q + 24'h000001;
         pwm_out <= cnt_q < high_time;
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the LED dimming duty control
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dim_pkg::*;
   logic mclk = 1'b0, sys_rst = 1'b1, rail = 1'b0, gnd = 1'b0, sup = 1'b0, en = 1'b0;
   logic run = 1'b0, p, started;
   logic [23:0] hi = 24'h0001f4, per = 24'h001388;
   logic [5:0] sink;
   logic [AMP_W-1:0] ref_v;
   wire pwm;
   int err_total = 0, tests_run = 0, cyc = 0, n;
   always #5 mclk = ~mclk;
   pwm_host i_pwm_host (.mclk(mclk), .run(run), .period(per), .high_time(hi),
      .pwm_out(pwm));
   led_dimming_duty_control #(.SOFT_DIRECT(1024), .SOFT_MIXED(1024)) i_led_dimming_duty_control (
      .mclk(mclk), .sys_rst(sys_rst), .strap_at_rail(rail), .strap_at_ground(gnd),
      .supply_ok(sup), .enable_in(en), .pwm_in(pwm), .sink_on(sink),
      .current_set_reference(ref_v), .started(started));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 100000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   // Restart from idle so each mode measures afresh
   task automatic start(input logic r, input logic g, input logic [23:0] h,
         input logic [23:0] pr);
      @(posedge mclk);
      en <= 1'b0;
      run <= 1'b0;
      repeat (5) @(posedge mclk);
      {rail, gnd, hi, per, run, en, sup} <= {r, g, h, pr, 3'b111};
      n = 0;
      while (started !== 1'b1 && n < 20000) begin
         wt(1);
         n++;
      end
   endtask
   // Count cycles with sinks lit over one input period
   task automatic lit(input int k);
      n = 0;
      repeat (k) begin
         wt(1);
         if (sink === 6'h3f) n++;
      end
   endtask
   task automatic t_direct;
      @(posedge mclk);
      {sup, en} <= 2'b11;
      wt(20);
      chk(started === 1'b0, "started without pwm");
      start(1'b1, 1'b0, 24'h0003e8, 24'h001388);
      chk(started === 1'b1, "no start");
      chk(ref_v < 9'h010, "no soft start ramp");
      n = 0;
      p = pwm;
      repeat (6000) begin
         wt(1);
         if (sink !== {6{p}}) n++;
         p = pwm;
      end
      chk(n == 0, "sinks not following pwm");
      chk(ref_v === AMP_FULL, "ramp short of full");
      $display("direct test done");
   endtask
   // Both straps high selects no dimming mode
   task automatic t_off;
      @(posedge mclk);
      {rail, gnd} <= 2'b11;
      wt(20);
      chk(sink === 6'h00 && ref_v === 9'h000, "sinks driven with both straps");
      $display("off test done");
   endtask
   task automatic t_mixed;
      start(1'b0, 1'b0, 24'h0009c4, 24'h001388);
      wt(8);
      chk(sink === 6'h00, "sinks lit before measurement");
      wt(16000);
      chk(ref_v === 9'(2500 * 511 / 5000) && sink === 6'h3f, "mixed high duty");
      start(1'b0, 1'b0, 24'h0001f4, 24'h001388);
      wt(16000);
      lit(5000);
      chk(ref_v === AMP_QUARTER && n >= 1996 && n <= 2004, "mixed low duty");
      $display("mixed test done");
   endtask
   task automatic t_dc;
      // Slower source keeps to the linear range; two periods pass before output
      start(1'b0, 1'b1, 24'h0001f4, 24'h002710);
      wt(21000);
      lit(10000);
      chk(ref_v === 9'(500 * 511 / 10000) && n == 10000, "pure dc level");
      @(posedge mclk);
      sup <= 1'b0;
      wt(2);
      chk(started === 1'b0 && sink === 6'h00, "supply loss kept sinks");
      $display("dc test done");
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      t_direct();
      t_off();
      t_mixed();
      t_dc();
      complete_run();
   end
endmodule
`default_nettype wire
